// [logic/lcdi_host.sv]
`timescale 1ns/1ps
module lcdi_host (
  input wire logic aclk,
  input wire logic aresetn,
  lcdi_bus_if.host bus,
  input wire logic [lcdi_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lcdi_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import lcdi_pkg::*;

  localparam logic [7:0] QMAX = 8'(SCL_QTR_CYC - 1);

  logic aw_got;
  logic w_got;
  logic [AXI_AW-1:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic wr_fire;
  logic cmd_go;
  logic [1:0] meta;
  logic [1:0] sync;
  logic busy;
  logic held;
  lcdi_op_e op;
  logic [8:0] txd;
  logic [8:0] rxsh;
  logic [3:0] bit_i;
  logic [1:0] qph;
  logic [7:0] qcnt;
  logic scl_oe;
  logic sda_oe;
  logic ack_rx;
  logic [7:0] rx_data;
  logic tick;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign cmd_go = wr_fire && (aw_q == REG_CMD) && ws_q[1] && !busy;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= '0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      s_axi_awready <= !(aw_got || (s_axi_awvalid && s_axi_awready)) || wr_fire;
      s_axi_wready <= !(w_got || (s_axi_wvalid && s_axi_wready)) || wr_fire;
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q == REG_CMD || aw_q == REG_STAT) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_OKAY;
        if (s_axi_araddr == REG_STAT) begin
          s_axi_rdata[STAT_BUSY_BIT] <= busy;
          s_axi_rdata[STAT_ACK_BIT] <= ack_rx;
          s_axi_rdata[STAT_HELD_BIT] <= held;
          s_axi_rdata[STAT_SCL_BIT] <= sync[1];
          s_axi_rdata[STAT_SDA_BIT] <= sync[0];
          s_axi_rdata[STAT_RX_LSB +: 8] <= rx_data;
        end else if (s_axi_araddr != REG_CMD) begin
          s_axi_rresp <= RESP_DECERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Line sampling
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 2'h3;
      sync <= 2'h3;
    end else begin
      meta <= {bus.scl, bus.sda};
      sync <= meta;
    end
  end

  // ****************************************
  // Bit engine, four quarter phases per step
  // ****************************************
  assign tick = busy && (qcnt == QMAX);

  always_ff @(posedge aclk) begin
    if (!aresetn || !busy || tick) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      held <= 1'b0;
      op <= LCDI_OP_START;
      txd <= 9'h1FF;
      rxsh <= 9'h000;
      bit_i <= 4'h0;
      qph <= 2'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      ack_rx <= 1'b0;
      rx_data <= 8'h00;
    end else if (cmd_go) begin
      busy <= 1'b1;
      op <= lcdi_op_e'(wd_q[CMD_OP_LSB +: 2]);
      txd <= (wd_q[CMD_OP_LSB +: 2] == 2'(LCDI_OP_WRITE)) ? {wd_q[CMD_DATA_LSB +: 8], 1'b1}
             : {8'hFF, wd_q[CMD_NACK_BIT]};
      bit_i <= 4'h0;
      qph <= 2'h0;
    end else if (tick) begin
      // Idle start waits for both lines high
      if (!(op == LCDI_OP_START && qph == 2'h0 && !held && !(sync[1] && sync[0]))) begin
        qph <= qph + 2'h1;
      end
      unique case (op)
        LCDI_OP_START: begin
          unique case (qph)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            2'h3: begin
              scl_oe <= 1'b1;
              held <= 1'b1;
              busy <= 1'b0;
            end
          endcase
        end
        LCDI_OP_STOP: begin
          unique case (qph)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            2'h3: begin
              held <= 1'b0;
              busy <= 1'b0;
            end
          endcase
        end
        LCDI_OP_WRITE, LCDI_OP_READ: begin
          unique case (qph)
            2'h0: begin
              sda_oe <= !txd[8];
              txd <= {txd[7:0], 1'b1};
            end
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
            end
            2'h3: begin
              scl_oe <= 1'b1;
              rxsh <= {rxsh[7:0], sync[0]};
              bit_i <= bit_i + 4'h1;
              if (bit_i == 4'h8) begin
                busy <= 1'b0;
                rx_data <= rxsh[7:0];
                ack_rx <= !sync[0];
              end
            end
          endcase
        end
      endcase
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe;

endmodule : lcdi_host

// [logic/lcdi_pkg.sv]
package lcdi_pkg;

  typedef logic [7:0] lcdi_byte_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int FILT_NS = 30;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCL_QTR_NS = 625;
  localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // Address and control byte layout
  // ****************************************
  localparam logic [4:0] ADDR_FIXED = 5'h0E;
  localparam int ADDR_RW_BIT = 0;
  localparam int ADDR_LOW_BIT = 1;
  localparam int ADDR_HIGH_BIT = 2;
  localparam int ADDR_FIXED_LSB = 3;
  localparam int CTRL_CONT_BIT = 7;
  localparam int CTRL_SEL_BIT = 6;

  // ****************************************
  // Controller registers
  // ****************************************
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_NACK_BIT = 10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT = 1;
  localparam int STAT_HELD_BIT = 2;
  localparam int STAT_SCL_BIT = 3;
  localparam int STAT_SDA_BIT = 4;
  localparam int STAT_RX_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {LCDI_OP_START, LCDI_OP_STOP, LCDI_OP_WRITE, LCDI_OP_READ} lcdi_op_e;

endpackage : lcdi_pkg

// [logic/lcdi_bus_if.sv]
`timescale 1ns/1ps
interface lcdi_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // ****************************************
  // Wired-and lines with pull-ups
  // ****************************************
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
                input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : lcdi_bus_if

// [logic/lcdi_dev.sv]
`timescale 1ns/1ps
// Summary of operation
// - Data changes while clock high are conditions
// - Data falling, clock high: start
// - Data rising, clock high: stop
// - Lines released high when idle
// - Master starts only on idle bus
// - Eight bits plus acknowledge, unlimited bytes
// - Addressed receiver acknowledges every byte
// - Acknowledger holds data low through pulse
// - Master nacks last read byte; release
// - Slave only; drives acknowledge and temperature
// - Address bits 7..3 are 01110
// - Bit 0 direction; bits 1,2 straps
// - Matching devices ack; others ignore transfer
// - Control byte bit 7 continues control
// - Control bit 6 routes: command or RAM
// - Display byte goes to RAM pointer
// - Master ends with stop or restart
// - Read direction returns temperature byte
// - Aborted data access invalidates pointer
module lcdi_dev (
  input wire logic aclk,
  input wire logic aresetn,
  lcdi_bus_if.dev bus,
  input wire logic addr_strap_low,
  input wire logic addr_strap_high,
  input wire lcdi_pkg::lcdi_byte_t temperature_byte,
  output lcdi_pkg::lcdi_byte_t rx_byte,
  output logic cmd_valid,
  output logic ram_wr,
  output logic ptr_invalid,
  output logic selected,
  output logic temp_read
);
  import lcdi_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_SKIP} lcdi_dst_e;
  typedef enum logic [1:0] {PH_ADDR, PH_CTRL, PH_DATA, PH_READ} lcdi_ph_e;

  localparam logic [1:0] FILT_LIM = 2'(FILT_CYC - 1);

  lcdi_dst_e state;
  lcdi_ph_e phase;
  logic [3:0] meta;
  logic [3:0] sync;
  logic [1:0] filt;
  logic [1:0] fcnt [2];
  logic scl_d;
  logic sda_d;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic control_continue_flag;
  logic target_select_flag;
  logic ack_seen;
  logic sda_oe;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;

  function automatic logic addr_hit(input logic [7:0] b, input logic lo, input logic hi);
    addr_hit = (b[7:ADDR_FIXED_LSB] == ADDR_FIXED) && (b[ADDR_LOW_BIT] == lo) && (b[ADDR_HIGH_BIT] == hi);
  endfunction : addr_hit

  // ****************************************
  // Input synchronisers and glitch filter
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 4'hC;
      sync <= 4'hC;
    end else begin
      meta <= {bus.scl, bus.sda, addr_strap_high, addr_strap_low};
      sync <= meta;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt <= 2'h3;
      fcnt[0] <= 2'h0;
      fcnt[1] <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync[i + 2] == filt[i]) begin
          fcnt[i] <= 2'h0;
        end else if (fcnt[i] == FILT_LIM) begin
          filt[i] <= sync[i + 2];
          fcnt[i] <= 2'h0;
        end else begin
          fcnt[i] <= fcnt[i] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= filt[1];
      sda_d <= filt[0];
    end
  end

  // ****************************************
  // Bus conditions
  // ****************************************
  assign scl_rise = filt[1] & ~scl_d;
  assign scl_fall = ~filt[1] & scl_d;
  // Data edge with clock high both cycles is a condition, never a bit
  assign start_det = filt[1] & scl_d & sda_d & ~filt[0];
  assign stop_det = filt[1] & scl_d & ~sda_d & filt[0];
  assign byte_done = (state == ST_RX) && scl_fall && (bitcnt == 4'h8);

  // ****************************************
  // Transfer state machine
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      phase <= PH_ADDR;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      control_continue_flag <= 1'b0;
      target_select_flag <= 1'b0;
      ack_seen <= 1'b0;
    end else if (start_det) begin
      state <= ST_RX;
      phase <= PH_ADDR;
      bitcnt <= 4'h0;
    end else if (stop_det) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE, ST_SKIP: begin
        end
        ST_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], filt[0]};
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_done) begin
            bitcnt <= 4'h0;
            unique case (phase)
              PH_ADDR: begin
                // Mismatch sleeps until the next start
                state <= addr_hit(shreg, sync[0], sync[1]) ? ST_ACK : ST_SKIP;
                phase <= shreg[ADDR_RW_BIT] ? PH_READ : PH_CTRL;
              end
              PH_CTRL: begin
                state <= ST_ACK;
                control_continue_flag <= shreg[CTRL_CONT_BIT];
                target_select_flag <= shreg[CTRL_SEL_BIT];
                phase <= PH_DATA;
              end
              PH_DATA, PH_READ: begin
                state <= ST_ACK;
                phase <= control_continue_flag ? PH_CTRL : PH_DATA;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (phase == PH_READ) begin
              state <= ST_TX;
              shreg <= temperature_byte;
            end else begin
              state <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt == 4'h7) begin
              state <= ST_TXACK;
              bitcnt <= 4'h0;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            ack_seen <= ~filt[0];
          end else if (scl_fall) begin
            if (ack_seen) begin
              state <= ST_TX;
              shreg <= temperature_byte;
            end else begin
              state <= ST_SKIP;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Data line drive
  // ****************************************
  // Only acknowledge and temperature bits ever pull the line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= (state == ST_ACK) || ((state == ST_TX) && !shreg[7]);
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe;

  // ****************************************
  // User side strobes
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_byte <= 8'h00;
      cmd_valid <= 1'b0;
      ram_wr <= 1'b0;
      ptr_invalid <= 1'b0;
      selected <= 1'b0;
      temp_read <= 1'b0;
    end else begin
      if (byte_done) begin
        rx_byte <= shreg;
      end
      cmd_valid <= byte_done && (phase == PH_DATA) && !target_select_flag;
      ram_wr <= byte_done && (phase == PH_DATA) && target_select_flag;
      // A clean stop or restart still counts its own clock rise as one bit
      ptr_invalid <= (start_det || stop_det) && (state == ST_RX) && (phase == PH_DATA)
                     && target_select_flag && (bitcnt > 4'h1);
      selected <= (state == ST_ACK) || (state == ST_TX) || (state == ST_TXACK)
                  || ((state == ST_RX) && (phase != PH_ADDR));
      temp_read <= scl_fall && (((state == ST_ACK) && (phase == PH_READ))
                   || ((state == ST_TXACK) && ack_seen)) && !start_det && !stop_det;
    end
  end

endmodule : lcdi_dev

// [verif/lcdi_chk.sv]
`timescale 1ns/1ps
module lcdi_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import lcdi_pkg::*;
  localparam int Q_LO = SCL_QTR_CYC - 2;
  localparam int Q_HI = SCL_QTR_CYC + 2;
  logic [7:0] hi_cnt;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************
  // Clock high time, restarted by a start
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !scl || (scl && $fell(sda))) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hFF) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end

  // ****************************************
  // Line properties
  // ****************************************
  sequence s_start;
    scl ##1 (scl && $fell(sda));
  endsequence
  sequence s_stop;
    scl ##1 (scl && $rose(sda));
  endsequence

  property p_idle_after_reset;
    $rose(aresetn) |-> scl && sda && !dev_sda_oe && !host_sda_oe;
  endproperty
  property p_dev_no_start;
    scl && $fell(sda) |-> host_sda_oe && !host_sda_o && !dev_sda_o && !host_scl_o;
  endproperty
  property p_dev_moves_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  property p_ack_low;
    $rose(scl) && dev_sda_oe |-> (dev_sda_oe && !sda) [*8];
  endproperty
  property p_start_fall;
    s_start |-> ##[Q_LO:Q_HI] $fell(scl);
  endproperty
  property p_start_idle;
    s_start |-> $past(sda, 100) && $past(scl, 50);
  endproperty
  property p_stop_prev;
    s_stop |-> $past(scl, 50);
  endproperty
  property p_stop_idle;
    s_stop |-> (scl && sda) [*8];
  endproperty
  property p_scl_high;
    $fell(scl) |-> hi_cnt inside {[60:64], [124:128]};
  endproperty

  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("lines not idle after reset");
  a_dev_no_start: assert property (p_dev_no_start)
    else $error("data fell with clock high, not by the host");
  a_dev_moves_low: assert property (p_dev_moves_low)
    else $error("device data moved with clock high");
  a_ack_low: assert property (p_ack_low)
    else $error("acknowledge not held low");
  a_start_fall: assert property (p_start_fall)
    else $error("clock did not fall after start");
  a_start_idle: assert property (p_start_idle)
    else $error("start without idle lines");
  a_stop_prev: assert property (p_stop_prev)
    else $error("stop without clock high");
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not released after stop");
  a_scl_high: assert property (p_scl_high)
    else $error("clock high time wrong");
endmodule : lcdi_chk

// [verif/lcdi_tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module lcdi_tb_top;
  import lcdi_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic strap_lo, strap_hi, cmd_valid, ram_wr, ptr_invalid, selected, temp_read;
  logic [7:0] temp, rx_byte, last_ram, last_cmd;
  int checked, n_mismatch, n_ram, n_cmd, n_temp, n_inv;

  lcdi_bus_if lcdi_bus_if_i ();
  lcdi_host lcdi_host_i (.aclk, .aresetn, .bus(lcdi_bus_if_i.host), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  lcdi_dev lcdi_dev_i (.aclk, .aresetn, .bus(lcdi_bus_if_i.dev), .addr_strap_low(strap_lo),
    .addr_strap_high(strap_hi), .temperature_byte(temp), .rx_byte, .cmd_valid, .ram_wr, .ptr_invalid,
    .selected, .temp_read);
  lcdi_chk lcdi_chk_i (.aclk, .aresetn, .host_scl_o(lcdi_bus_if_i.host_scl_o),
    .host_scl_oe(lcdi_bus_if_i.host_scl_oe), .host_sda_o(lcdi_bus_if_i.host_sda_o),
    .host_sda_oe(lcdi_bus_if_i.host_sda_oe), .dev_sda_o(lcdi_bus_if_i.dev_sda_o),
    .dev_sda_oe(lcdi_bus_if_i.dev_sda_oe), .scl(lcdi_bus_if_i.scl), .sda(lcdi_bus_if_i.sda));

  // ****************************************
  // Clock, pulse counters, watchdog
  // ****************************************
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (ram_wr === 1'b1) begin
      n_ram++;
      last_ram = rx_byte;
    end
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = rx_byte;
    end
    if (temp_read === 1'b1) n_temp++;
    if (ptr_invalid === 1'b1) n_inv++;
  end
  initial begin
    repeat (90000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic host_op(input lcdi_op_e op, input logic [7:0] d, input logic nk, output logic [31:0] st);
    logic [1:0] r;
    int i;
    axi_wr(REG_CMD, {21'h0, nk, op, d}, r);
    i = 0;
    do begin
      axi_rd(REG_STAT, st, r);
      i++;
    end while (st[STAT_BUSY_BIT] === 1'b1 && i < 2000);
    `CHK("busy", 1'b0, st[STAT_BUSY_BIT])
  endtask : host_op
  task automatic op(input lcdi_op_e o);
    logic [31:0] st;
    host_op(o, 8'h00, 1'b0, st);
  endtask : op
  task automatic wbyte(input logic [7:0] d, input logic ack);
    logic [31:0] st;
    host_op(LCDI_OP_WRITE, d, 1'b0, st);
    `CHK("ack", ack, st[STAT_ACK_BIT])
  endtask : wbyte
  task automatic clr;
    n_ram = 0;
    n_cmd = 0;
    n_temp = 0;
  endtask : clr

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h0C, 32'h0000_0200, r);
    `CHK("wr_unmapped", RESP_DECERR, r)
    axi_rd(8'h08, d, r);
    `CHK("rd_unmapped", RESP_DECERR, r)
    axi_rd(REG_STAT, d, r);
    `CHK("idle_lines", 3'b110, {d[STAT_SCL_BIT], d[STAT_SDA_BIT], d[STAT_BUSY_BIT]})
  endtask : t_regs
  task automatic t_ram;
    clr();
    op(LCDI_OP_START);
    wbyte(8'h72, 1'b1);
    `CHK("selected", 1'b1, selected)
    wbyte(8'h40, 1'b1);
    wbyte(8'hA5, 1'b1);
    `CHK("ram_byte", 8'hA5, last_ram)
    wbyte(8'h5A, 1'b1);
    `CHK("ram_cnt", 2, n_ram)
    `CHK("ram_byte", 8'h5A, last_ram)
    op(LCDI_OP_STOP);
    `CHK("selected", 1'b0, selected)
    `CHK("cmd_cnt", 0, n_cmd)
  endtask : t_ram
  task automatic t_route;
    clr();
    op(LCDI_OP_START);
    wbyte(8'h72, 1'b1);
    wbyte(8'h80, 1'b1);
    wbyte(8'h11, 1'b1);
    `CHK("cmd_byte", 8'h11, last_cmd)
    wbyte(8'hC0, 1'b1);
    wbyte(8'h22, 1'b1);
    `CHK("ram_byte", 8'h22, last_ram)
    wbyte(8'h3F, 1'b1);
    wbyte(8'h44, 1'b1);
    wbyte(8'h45, 1'b1);
    `CHK("cmd_cnt", 3, n_cmd)
    `CHK("cmd_byte", 8'h45, last_cmd)
    op(LCDI_OP_START);
    wbyte(8'h72, 1'b1);
    wbyte(8'h40, 1'b1);
    wbyte(8'h66, 1'b1);
    `CHK("ram_cnt", 2, n_ram)
    op(LCDI_OP_STOP);
    `CHK("abort_cnt", 0, n_inv)
  endtask : t_route
  task automatic t_straps;
    clr();
    strap_hi <= 1'b1;
    strap_lo <= 1'b0;
    repeat (8) @(posedge aclk);
    op(LCDI_OP_START);
    wbyte(8'h72, 1'b0);
    wbyte(8'h40, 1'b0);
    wbyte(8'h55, 1'b0);
    `CHK("ram_cnt", 0, n_ram)
    `CHK("selected", 1'b0, selected)
    op(LCDI_OP_START);
    wbyte(8'h74, 1'b1);
    op(LCDI_OP_STOP);
    op(LCDI_OP_START);
    wbyte(8'hF4, 1'b0);
    op(LCDI_OP_STOP);
    strap_hi <= 1'b0;
    strap_lo <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask : t_straps
  task automatic t_read;
    logic [31:0] st;
    clr();
    op(LCDI_OP_START);
    wbyte(8'h73, 1'b1);
    host_op(LCDI_OP_READ, 8'h00, 1'b0, st);
    `CHK("temp1", temp, st[STAT_RX_LSB +: 8])
    host_op(LCDI_OP_READ, 8'h00, 1'b1, st);
    `CHK("temp2", temp, st[STAT_RX_LSB +: 8])
    repeat (20) @(posedge aclk);
    `CHK("dev_release", 1'b0, lcdi_bus_if_i.dev_sda_oe)
    `CHK("temp_cnt", 2, n_temp)
    op(LCDI_OP_STOP);
    `CHK("ram_cnt", 0, n_ram)
  endtask : t_read

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    strap_lo = 1'b1;
    strap_hi = 1'b0;
    temp = 8'h3C;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_regs();
    t_ram();
    t_route();
    t_straps();
    t_read();
    summarize();
  end
endmodule : lcdi_tb_top
